// ===== include/dbs_pkg.sv
// package: constants and types for the dynamic bus sizing transfer unit
`default_nettype none
package dbs_pkg;
  // ----------------------------------------------------------------
  // size codes (bytes still to move) and offsets
  // ----------------------------------------------------------------
  localparam logic [1:0] SIZE_LONG  = 2'h0;
  localparam logic [1:0] SIZE_BYTE  = 2'h1;
  localparam logic [1:0] SIZE_WORD  = 2'h2;
  localparam logic [1:0] SIZE_THREE = 2'h3;
  localparam logic [1:0] OFS_0      = 2'h0;
  localparam logic [1:0] OFS_1      = 2'h1;
  localparam logic [1:0] OFS_2      = 2'h2;
  localparam logic [1:0] OFS_3      = 2'h3;
  // ----------------------------------------------------------------
  // acknowledge pair {hi,lo}, active low
  // ----------------------------------------------------------------
  localparam logic [1:0] ACK_WAIT   = 2'h3;
  localparam logic [1:0] ACK_PORT8  = 2'h2;
  localparam logic [1:0] ACK_PORT16 = 2'h1;
  localparam logic [1:0] ACK_PORT32 = 2'h0;
  // ----------------------------------------------------------------
  // operation kinds and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_READ_LONG = 2'h0;
  localparam logic [1:0] OP_WRITE_BYTE = 2'h1;
  localparam logic [1:0] OP_RMW_BYTE   = 2'h2;
  localparam logic [31:0] DATA_RESET   = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_CYCLE = 3'b010,
    ST_RMW_W = 3'b100
  } dbs_state_e;
endpackage
`default_nettype wire

// ===== logic/dbs_transfer.sv
// module: operand transfer unit with dynamic bus sizing
//
// Operation
// - low address lines carry byte offset 0..3
// - size shows bytes remaining; ack means width
// - long-word base on address bits 31..2
// - start only long read, byte write/rmw
// - long and three-byte lane routing
// - word and byte lane routing
// - 16-bit read: first cycle code 0000
// - 16-bit ack: latch, next cycle 1010
// - 8-bit port: four one-byte cycles
// - drive all lanes on every write
// - hold processor off bus during search
// - no long operation assumes a 32-bit port
`timescale 1ns/100ps
`default_nettype none
module dbs_transfer
  import dbs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // table search request side
  input  wire logic        reqValid,
  input  wire logic [1:0]  reqKind,
  input  wire logic [31:0] reqAddr,
  input  wire logic [7:0]  reqWrByte,
  input  wire logic        searchActive,
  output logic             reqReady,
  output logic             rdValid,
  output logic [31:0]      rdData,
  output logic             cpuBusHold,
  // physical bus side
  output logic             busCycle,
  output logic [31:0]      busAddr,
  output logic             xfer_size_hi,
  output logic             xfer_size_lo,
  output logic             busWrite,
  output logic             busRmw,
  input  wire logic        width_ack_hi,
  input  wire logic        width_ack_lo,
  input  wire logic [31:0] dataIn,
  output logic [31:0]      dataOut,
  output logic             dataOutEn
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // bytes a port of the acknowledged width takes, before capping by what remains
  function automatic logic [2:0] portBytes(input logic [1:0] ack);
    case (ack)
      ACK_PORT8:  portBytes = 3'h1;
      ACK_PORT16: portBytes = 3'h2;
      default:    portBytes = 3'h4;
    endcase
  endfunction

  // remaining byte count to size code: 4 -> 00 (long)
  function automatic logic [1:0] sizeCode(input logic [2:0] rem);
    sizeCode = rem[1:0];
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dbs_state_e  state_q;
  logic [29:0] base_q;
  logic [1:0]  ofs_q;
  logic [2:0]  rem_q;
  logic [1:0]  kind_q;
  logic [31:0] opnd_q;
  logic [31:0] asm_q;
  logic [1:0]  ackPair;
  logic        ackDone;
  logic [2:0]  took;
  logic        lastCycle;
  // size code of the current cycle, kept as a net so its bits can be picked
  logic [1:0]  sizeNow;

  assign ackPair   = {width_ack_hi, width_ack_lo};
  assign ackDone   = (state_q != ST_IDLE) && (ackPair != ACK_WAIT);
  // ack tells width only; bytes moved are min(width, remaining)
  assign took      = (portBytes(ackPair) >= rem_q) ? rem_q : portBytes(ackPair);
  assign lastCycle = (took == rem_q);
  assign sizeNow   = sizeCode(rem_q);

  // notes for users of this block:
  // - bus error and retry are not handled here; a slave that never
  //   acknowledges leaves the unit waiting, so an outside watchdog is needed
  // - the offset only ever grows within one operand, so a wider ack on a
  //   later cycle simply takes whatever remains
  // - writes are always single bytes, so no write ever splits

  // ----------------------------------------------------------------
  // control sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      base_q  <= 30'h0000_0000;
      ofs_q   <= OFS_0;
      rem_q   <= 3'h0;
      kind_q  <= OP_READ_LONG;
      opnd_q  <= DATA_RESET;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (reqValid) begin
            base_q <= reqAddr[31:2];
            kind_q <= reqKind;
            opnd_q <= {24'h00_0000, reqWrByte};
            if (reqKind == OP_READ_LONG) begin
              ofs_q <= OFS_0;
              rem_q <= 3'h4;
            end else begin
              ofs_q <= OFS_3;
              rem_q <= 3'h1;
            end
            state_q <= ST_CYCLE;
          end
        end
        ST_CYCLE: begin
          if (ackDone) begin
            if (lastCycle) begin
              // rmw goes on to write the modified byte back at the same place
              if (kind_q == OP_RMW_BYTE) begin
                state_q <= ST_RMW_W;
              end else begin
                state_q <= ST_IDLE;
              end
            end else begin
              ofs_q <= ofs_q + took[1:0];
              rem_q <= rem_q - took;
            end
          end
        end
        ST_RMW_W: begin
          if (ackDone) begin
            state_q <= ST_IDLE;
          end
        end
        // an illegal one-hot code falls back to idle rather than locking up
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read assembly, operand byte 0 most significant
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      asm_q   <= DATA_RESET;
      rdData  <= DATA_RESET;
      rdValid <= 1'b0;
    end else begin
      rdValid <= 1'b0;
      if (state_q == ST_CYCLE && ackDone) begin
        // narrow ports sit on the high lanes, so the first taken byte is lane 31..24
        logic [31:0] nxt;
        nxt = asm_q;
        for (int i = 0; i < 4; i++) begin
          if (i >= ofs_q && i < ofs_q + took) begin
            nxt[31-8*i -: 8] = (ackPair == ACK_PORT32) ?
                               dataIn[31-8*i -: 8] :
                               dataIn[31-8*(i-ofs_q) -: 8];
          end
        end
        asm_q <= nxt;
        if (lastCycle) begin
          rdData  <= nxt;
          rdValid <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // bus outputs and lane multiplexer
  // ----------------------------------------------------------------
  // the mux follows size and offset only, never the port width, so the
  // same byte appears on every lane a narrower port might be wired to
  logic [7:0] op [4];
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      op[i] = opnd_q[31-8*i -: 8];
    end
    // write data is the byte at offset 3, held as operand byte 3
    op[3] = opnd_q[7:0];
    case ({sizeCode(rem_q), ofs_q})
      {SIZE_LONG, OFS_0}:  dataOut = {op[0], op[1], op[2], op[3]};
      {SIZE_THREE, OFS_1}: dataOut = {op[1], op[1], op[2], op[3]};
      {SIZE_WORD, OFS_2}:  dataOut = {op[2], op[3], op[2], op[3]};
      {SIZE_BYTE, OFS_3}:  dataOut = {op[3], op[3], op[3], op[3]};
      default:             dataOut = {op[0], op[1], op[2], op[3]};
    endcase
  end

  assign busCycle     = (state_q != ST_IDLE);
  assign busAddr      = {base_q, ofs_q};
  assign xfer_size_hi = sizeNow[1];
  assign xfer_size_lo = sizeNow[0];
  // rmw is flagged for both halves so the pair stays indivisible on the bus
  assign busWrite     = ((state_q == ST_CYCLE) && (kind_q == OP_WRITE_BYTE)) ||
                        (state_q == ST_RMW_W);
  assign busRmw       = (kind_q == OP_RMW_BYTE) && busCycle;
  // all four lanes driven in every write; external strobes pick the lanes
  assign dataOutEn    = busWrite;
  // ready is decoded from the idle state only, so back-to-back requests pass through one idle cycle
  assign reqReady     = (state_q == ST_IDLE);
  // narrow ports stretch this window, delaying the processor
  assign cpuBusHold   = searchActive || busCycle;
endmodule
`default_nettype wire

// ===== sim/dbs_slave.sv
// partner: memory port of selectable width and wait count
`timescale 1ns/100ps
`default_nettype none
module dbs_slave
  import dbs_pkg::*;
#(parameter logic [31:0] MEM = 32'h1122_3344)
(
  input  wire logic        clk, rst_n, busCycle, busWrite,
  input  wire logic [1:0]  portAck, waitN,
  input  wire logic [31:0] busAddr, dataOut,
  output logic             width_ack_hi, width_ack_lo,
  output logic [31:0]      dataIn,
  output logic [7:0]       wrByte,
  output int               nAck
);
  logic [1:0] cnt;
  int         sh;
  assign sh = 8 * (3 - int'(busAddr[1:0]));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {width_ack_hi, width_ack_lo} <= ACK_WAIT;
      cnt <= 2'h0;
      dataIn <= 32'h0;
      wrByte <= 8'h0;
      nAck <= 0;
    end else if ({width_ack_hi, width_ack_lo} != ACK_WAIT) begin
      {width_ack_hi, width_ack_lo} <= ACK_WAIT;
      cnt <= 2'h0;
      dataIn <= ~dataIn; // released lanes must never look valid
      nAck <= nAck + 1;
      if (busWrite) wrByte <= portAck == ACK_PORT8 ? dataOut[31:24] :
          portAck == ACK_PORT16 ? dataOut[23:16] : dataOut[7:0];
    end else if (busCycle && cnt == waitN) begin
      {width_ack_hi, width_ack_lo} <= portAck;
      dataIn <= ~dataIn;
      if (portAck == ACK_PORT32) dataIn <= MEM;
      else if (portAck == ACK_PORT16) dataIn[31:16] <= busAddr[1] ? MEM[15:0] : MEM[31:16];
      else dataIn[31:24] <= MEM[sh +: 8];
    end else if (busCycle) cnt <= cnt + 2'h1;
  end
endmodule
`default_nettype wire

// ===== sim/dbs_transfer_assertions.sv
// checker: sizing, routing and handshake properties of the transfer unit
`timescale 1ns/100ps
`default_nettype none
module dbs_transfer_assertions
  import dbs_pkg::*;
(
  input wire logic        clk, rst_n, reqValid, reqReady, searchActive, busCycle, busWrite,
  input wire logic        xfer_size_hi, xfer_size_lo, width_ack_hi, width_ack_lo,
  input wire logic        dataOutEn, cpuBusHold, rdValid,
  input wire logic [1:0]  reqKind,
  input wire logic [31:0] reqAddr, busAddr, dataOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] ack, ofs;
  assign ack = {width_ack_hi, width_ack_lo};
  assign ofs = busAddr[1:0];
  sequence s_done; busCycle && ack != ACK_WAIT; endsequence
  property p_size; busCycle |-> {xfer_size_hi, xfer_size_lo} == 2'(3'h4 - ofs); endproperty
  a_size: assert property (p_size) else $error("size");
  property p_start; reqValid && reqReady |=> busCycle && busAddr ==
    {$past(reqAddr[31:2]), ($past(reqKind) == OP_READ_LONG ? OFS_0 : OFS_3)}; endproperty
  a_start: assert property (p_start) else $error("start");
  property p_wait; busCycle && ack == ACK_WAIT |=> busCycle && $stable(busAddr); endproperty
  a_wait: assert property (p_wait) else $error("wait");
  property p_half; busCycle && ack == ACK_PORT16 && ofs == OFS_0
    |=> busCycle && busAddr == $past(busAddr) + 32'h2; endproperty
  a_half: assert property (p_half) else $error("half");
  property p_byte; busCycle && ack == ACK_PORT8 && !busWrite && ofs != OFS_3
    |=> busCycle && busAddr == $past(busAddr) + 32'h1; endproperty
  a_byte: assert property (p_byte) else $error("byte");
  property p_wr; busWrite |-> dataOutEn && ofs == OFS_3 && dataOut == {4{dataOut[7:0]}}; endproperty
  a_wr: assert property (p_wr) else $error("write");
  property p_hold; busCycle || searchActive |-> cpuBusHold; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_last; s_done ##0 (!busWrite && (ack == ACK_PORT32 || ofs == OFS_3 ||
    (ack == ACK_PORT16 && ofs == OFS_2))) |=> rdValid; endproperty
  a_last: assert property (p_last) else $error("last");
endmodule
bind dbs_transfer dbs_transfer_assertions dbs_transfer_assertions_i (.*);
`default_nettype wire

// ===== sim/tb_dbs_transfer.sv
// testbench: long reads, byte writes and rmw through 8, 16 and 32-bit ports
`timescale 1ns/100ps
`default_nettype none
module tb_dbs_transfer;
  import dbs_pkg::*;
  localparam logic [1:0] ACKS [3] = '{ACK_PORT32, ACK_PORT16, ACK_PORT8};
  logic        clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, searchActive = 1'b0;
  logic        reqReady, rdValid, cpuBusHold, busCycle, busWrite, busRmw, dataOutEn;
  logic        xfer_size_hi, xfer_size_lo, width_ack_hi, width_ack_lo;
  logic [1:0]  reqKind = 2'h0, portAck = 2'h0, waitN = 2'h0;
  logic [7:0]  reqWrByte = 8'h0, wrByte;
  logic [31:0] reqAddr = 32'h0, busAddr, rdData, dataIn, dataOut;
  int          nAck, total_checks = 0, n_mismatch = 0;
  logic        rmwSeen = 1'b0;
  always #2 clk = ~clk;
  dbs_transfer dbs_transfer_i (.*);
  dbs_slave dbs_slave_i (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // port i also sets i wait states, so slow slaves are covered
  task automatic run(input logic [1:0] kind, input int i, output int cyc);
    int n, a0;
    n = 0;
    rmwSeen = 1'b0;
    @(posedge clk);
    a0 = nAck;
    portAck <= ACKS[i];
    waitN <= 2'(i);
    reqKind <= kind;
    reqAddr <= 32'h0000_4a37 + 32'(i) * 32'h100;
    reqWrByte <= {2'(i), kind, 4'ha};
    reqValid <= 1'b1;
    @(posedge clk);
    reqValid <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (busRmw) rmwSeen = 1'b1;
    end while (!reqReady && n < 100);
    if (n == 100) begin
      n_mismatch++;
      results();
    end
    cyc = nAck - a0;
  endtask
  task automatic rdLong(input int i);
    int cyc;
    run(OP_READ_LONG, i, cyc);
    check(rdData, 32'h1122_3344);
    check(32'(cyc), 32'(1 << i));
    check(32'(rmwSeen), 32'h0);
  endtask
  task automatic byteOp(input logic [1:0] kind, input int i);
    int cyc;
    run(kind, i, cyc);
    check(32'(wrByte), 32'({2'(i), kind, 4'ha}));
    check(32'(cyc), kind == OP_RMW_BYTE ? 32'h2 : 32'h1);
    check(32'(rmwSeen), kind == OP_RMW_BYTE ? 32'h1 : 32'h0);
  endtask
  task automatic holdOff();
    @(posedge clk);
    searchActive <= 1'b1;
    @(posedge clk);
    #1;
    check(32'(cpuBusHold), 32'h1);
    @(posedge clk);
    searchActive <= 1'b0;
    @(posedge clk);
    #1;
    check(32'(cpuBusHold), 32'h0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rdLong(i);
      byteOp(OP_WRITE_BYTE, i);
      byteOp(OP_RMW_BYTE, i);
    end
    holdOff();
    results();
  end
endmodule
`default_nettype wire
